// ### hw/dtm_dram.sv
// dram end: write-leveling exit and calibration readout mode
// assumes commands are taken synchronously on clk_sys
// ************************************************************
// Overview of operation
// - one prime dq feeds back, others low
// - controller strobes meet write pulse widths
// - controller releases strobes after last edge
// - dq undefined until tmod after exit
// - controller drives odt low at exit
// - exit mrs only after termination off
// - mr1 a7 cleared leaves write leveling
// - controller waits tmrd, tmod after exit
// - mr3 a2 toggles calibration readout mode
// - all banks idle before readout enable
// - reads redirected to calibration register
// - only reads allowed; reset still works
// - auto precharge read acts as read
// - enable low means normal array operation
// - dq0 carries data, others copy
// - a1:a0 zero; bank, upper bits ignored
// - a2 picks nibble order
// - a12 selects burst chop on fly
// - data after read latency al+cl
// - no calibration read before dll lock
// - beat 0 lsb, beat 7 msb
// - select 00 gives alternating pattern
// - wait tmrd, tmod; no writes meanwhile
// - wait tmprr, then disable, wait again
// ************************************************************
//
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module dtm_dram (
	dtm_if.dram       bus,
	output logic      wl_active,
	output logic      ro_active,
	output logic      array_read,
	output logic      array_write,
	output logic      cmd_illegal
);
	import dtm_pkg::*;

	// ************************************************************
	// mode state
	// ************************************************************
	logic       wl_q;
	logic       ro_q;
	logic [1:0] loc_q;
	logic [7:0] undef_cnt_q;   // tmod window after wl exit
	logic       stop_seen_q;
	logic       dqs_oe_d1_q;
	logic       bc_otf_q;      // mr0 lets a12 choose chop; fixed on here
	logic [2:0] dll_cnt_q;

	wire mrs1 = (bus.cmd == DTM_CMD_MRS) && (bus.mr_sel == MR_SEL_MR1);
	wire mrs3 = (bus.cmd == DTM_CMD_MRS) && (bus.mr_sel == MR_SEL_MR3);
	wire is_rd = (bus.cmd == DTM_CMD_RD) || (bus.cmd == DTM_CMD_RDA);

	// write-leveling mode bit from mr1
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			wl_q <= 1'b0;
		end else if (mrs1) begin
			wl_q <= bus.addr[MR1_WL_BIT];
		end
	end

	// readout enable and location select from mr3; reset clears it
	// reset must work even in readout mode, so it outranks every command
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			ro_q  <= 1'b0;
			loc_q <= 2'h0;
		end else if (mrs3) begin
			ro_q  <= bus.addr[MR3_RO_BIT];
			loc_q <= bus.addr[1:0];
		end
	end

	// undefined dq window: strobe release until tmod past exit mrs
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			dqs_oe_d1_q <= 1'b0;
			stop_seen_q <= 1'b0;
			undef_cnt_q <= 8'h00;
		end else begin
			dqs_oe_d1_q <= bus.dqs_oe;
			if (mrs1 && wl_q && !bus.addr[MR1_WL_BIT]) begin
				undef_cnt_q <= T_MOD_CYC;
			end else if (undef_cnt_q != 8'h00) begin
				undef_cnt_q <= undef_cnt_q - 8'h01;
				if (undef_cnt_q == 8'h01) begin
					stop_seen_q <= 1'b0; // window over
				end
			end
			// set placed last so a strobe stop wins over a window end in one cycle
			if (wl_q && dqs_oe_d1_q && !bus.dqs_oe) begin
				stop_seen_q <= 1'b1;
			end
		end
	end

	// dll lock after a short settle; fixed on-the-fly chop permission
	// lock time is a model figure; mr0 is not modelled, so chop is always allowed
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			dll_cnt_q <= 3'h0;
			bc_otf_q  <= 1'b1;
		end else if (dll_cnt_q != 3'h7) begin
			dll_cnt_q <= dll_cnt_q + 3'h1;
		end
	end
	assign bus.dll_locked = (dll_cnt_q == 3'h7);

	// ************************************************************
	// calibration read pipeline
	// ************************************************************
	logic [3:0] lat_q;     // counts read latency
	logic       pend_q;
	logic       pend_hi_q; // upper nibble first
	logic       pend_bc_q; // burst chop
	logic [2:0] beat_q;
	logic [2:0] beat_end_q;
	logic       burst_q;

	// a read in readout mode ignores bank, a10 and upper column bits
	// limitation: one read in flight; a read taken before the pending one
	// leaves its latency count replaces it, so bursts must be spaced out
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			pend_q     <= 1'b0;
			pend_hi_q  <= 1'b0;
			pend_bc_q  <= 1'b0;
			lat_q      <= 4'h0;
			burst_q    <= 1'b0;
			beat_q     <= 3'h0;
			beat_end_q <= 3'h0;
		end else begin
			if (ro_q && is_rd && bus.dll_locked) begin
				pend_q    <= 1'b1;
				pend_bc_q <= bc_otf_q && !bus.addr[ADDR_BC_BIT];
				pend_hi_q <= bus.addr[ADDR_NIB_BIT];
				lat_q     <= READ_LAT_CYC - 4'h1;
			end else if (pend_q) begin
				if (lat_q == 4'h0) begin
					pend_q     <= 1'b0;
					burst_q    <= 1'b1;
					beat_q     <= (pend_bc_q && pend_hi_q) ? 3'h4 : 3'h0;
					beat_end_q <= (pend_bc_q && !pend_hi_q) ? 3'h3 : 3'h7;
				end else begin
					lat_q <= lat_q - 4'h1;
				end
			end
			if (burst_q && !(pend_q && lat_q == 4'h0)) begin
				if (beat_q == beat_end_q) begin
					burst_q <= 1'b0;
				end else begin
					beat_q <= beat_q + 3'h1;
				end
			end
		end
	end

	// selected bit for this beat; reserved selects read zero
	wire cal_bit = (loc_q == LOC_PATTERN) ? TRAIN_PATTERN[beat_q] : 1'b0;

	// ************************************************************
	// dq drive
	// ************************************************************
	// dq: leveling feedback on dq0 only, others low; readout replicates dq0
	logic       fb_q;
	always_ff @(posedge bus.clk_sys) begin
		if (bus.rst) begin
			fb_q <= 1'b0;
		end else if (wl_q && bus.dqs_oe && bus.dqs_o) begin
			fb_q <= 1'b1; // sampled clock is high at strobe edge in this model
		end else if (!wl_q) begin
			fb_q <= 1'b0;
		end
	end

	// data beats outrank feedback; the undefined window outranks feedback
	always_comb begin
		bus.dq_o     = 8'h00;
		bus.dq_oe    = 8'h00;
		bus.dq_valid = 1'b0;
		if (burst_q) begin
			bus.dq_o     = {8{cal_bit}};
			bus.dq_oe    = 8'hff;
			bus.dq_valid = 1'b1;
		end else if (wl_q && !stop_seen_q) begin
			bus.dq_o  = {7'h00, fb_q};
			bus.dq_oe = 8'hff;
		end else if (stop_seen_q) begin
			bus.dq_o  = 8'h00; // undefined region, modelled as released
			bus.dq_oe = 8'h00;
		end
	end

	// ************************************************************
	// status outputs
	// ************************************************************
	// pulses are combinational and stand only while the command is on the bus
	assign wl_active   = wl_q;
	assign ro_active   = ro_q;
	assign array_read  = !ro_q && is_rd;
	assign array_write = !ro_q && (bus.cmd == DTM_CMD_WR);
	assign cmd_illegal = ro_q && !is_rd && (bus.cmd != DTM_CMD_NOP)
		&& !mrs3;
endmodule : dtm_dram
`default_nettype wire

// ### hw/dtm_pkg.sv
// package for the dram training-mode model: command codes, mode bits, timings
// assumes a single 125 MHz clock shared by both ends
`default_nettype none
package dtm_pkg;
	// command encodings on the abstract command bus
	typedef enum logic [2:0] {
		DTM_CMD_NOP   = 3'h0,
		DTM_CMD_MRS   = 3'h1,
		DTM_CMD_RD    = 3'h2,
		DTM_CMD_RDA   = 3'h3,
		DTM_CMD_WR    = 3'h4,
		DTM_CMD_OTHER = 3'h5
	} dtm_cmd_t;
	localparam logic [1:0] MR_SEL_MR1       = 2'h1;
	localparam logic [1:0] MR_SEL_MR3       = 2'h3;
	localparam int         MR1_WL_BIT       = 7;
	localparam int         MR3_RO_BIT       = 2;
	localparam int         ADDR_BC_BIT      = 12;
	localparam int         ADDR_NIB_BIT     = 2;
	localparam logic [7:0] TRAIN_PATTERN    = 8'haa; // beat0=lsb=0, beat1=1, ...
	localparam logic [1:0] LOC_PATTERN      = 2'h0;
	// timing figures in ns and the derived cycle counts (8 ns clock)
	localparam int         CLK_PERIOD_NS    = 8;
	localparam int         T_MRD_NS         = 32;
	localparam int         T_MOD_NS         = 120;
	localparam int         T_MPRR_NS        = 8;
	localparam int         T_RP_NS          = 16;
	localparam logic [7:0] T_MRD_CYC  = 8'((T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] T_MOD_CYC  = 8'((T_MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] T_MPRR_CYC = 8'((T_MPRR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] T_RP_CYC   = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] READ_LAT_CYC     = 4'h6; // additive plus cas latency
	localparam logic [7:0] CAL_READS        = 8'h04; // reads before capture is done
	// controller state machine
	typedef enum logic [3:0] {
		DTM_C_IDLE   = 4'h0,
		DTM_C_WLSTOP = 4'h1,
		DTM_C_WLODT  = 4'h2,
		DTM_C_WLMRS  = 4'h3,
		DTM_C_WLWAIT = 4'h4,
		DTM_C_PRE    = 4'h5,
		DTM_C_ROMRS  = 4'h6,
		DTM_C_ROWAIT = 4'h7,
		DTM_C_RDCMD  = 4'h8,
		DTM_C_RDGAP  = 4'h9,
		DTM_C_OFFMRS = 4'ha,
		DTM_C_OFFWT  = 4'hb
	} dtm_cstate_t;
endpackage : dtm_pkg
`default_nettype wire

// ### hw/dtm_if.sv
// interface joining the training controller and the dram model
// assumes both ends share clk_sys and rst
`default_nettype none
interface dtm_if (
	input wire logic clk_sys,
	input wire logic rst
);
	import dtm_pkg::*;
	dtm_cmd_t    cmd;        // command, one cycle each
	logic [1:0]  mr_sel;     // mode register selected by mrs
	logic [15:0] addr;       // address bits a[15:0]
	logic        odt;        // on-die termination request
	logic        dqs_o;      // strobe from controller
	logic        dqs_oe;     // controller drives the strobe
	logic [7:0]  dq_o;       // dq from device
	logic [7:0]  dq_oe;      // device drives dq
	logic        dq_valid;   // device burst beat marker
	logic        dll_locked; // device dll is locked
	modport ctrl (
		input  clk_sys, rst, dq_o, dq_oe, dq_valid, dll_locked,
		output cmd, mr_sel, addr, odt, dqs_o, dqs_oe
	);
	modport dram (
		input  clk_sys, rst, cmd, mr_sel, addr, odt, dqs_o, dqs_oe,
		output dq_o, dq_oe, dq_valid, dll_locked
	);
endinterface : dtm_if
`default_nettype wire

// ### hw/dtm_ctrl.sv
// controller end: leaves write leveling, then runs calibration reads
// assumes the dram end honours its own rules; start is a one-cycle pulse
`default_nettype none
module dtm_ctrl (
	input  wire logic  clk_sys,
	input  wire logic  rst,
	dtm_if.ctrl        bus,
	input  wire logic  start,
	output logic       busy,
	output logic       done,
	output logic [7:0] cal_data_q
);
	import dtm_pkg::*;

	dtm_cstate_t st_q;
	logic [7:0]  wait_q;
	logic [7:0]  reads_q;
	logic [2:0]  bit_q;

	// ************************************************************
	// sequencer
	// ************************************************************
	// one always_ff steps states and drives the command bus
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q       <= DTM_C_IDLE;
			wait_q     <= 8'h00;
			reads_q    <= 8'h00;
			bus.cmd    <= DTM_CMD_NOP;
			bus.mr_sel <= 2'h0;
			bus.addr   <= 16'h0000;
			bus.odt    <= 1'b1;
			bus.dqs_o  <= 1'b0;
			bus.dqs_oe <= 1'b0;
			done       <= 1'b0;
		end else begin
			bus.cmd <= DTM_CMD_NOP;
			done    <= 1'b0;
			if (wait_q != 8'h00) begin
				wait_q <= wait_q - 8'h01;
			end
			case (st_q)
				DTM_C_IDLE: begin
					if (start) begin
						bus.dqs_oe <= 1'b1;
						bus.dqs_o  <= 1'b1; // last rising edge, tdqsh met by a full cycle
						st_q       <= DTM_C_WLSTOP;
					end
				end
				DTM_C_WLSTOP: begin
					bus.dqs_oe <= 1'b0;
					bus.dqs_o  <= 1'b0;
					bus.odt    <= 1'b0;
					wait_q     <= T_MOD_CYC; // termination off time
					st_q       <= DTM_C_WLODT;
				end
				DTM_C_WLODT: begin
					if (wait_q == 8'h00) begin
						st_q <= DTM_C_WLMRS;
					end
				end
				DTM_C_WLMRS: begin
					bus.cmd    <= DTM_CMD_MRS;
					bus.mr_sel <= MR_SEL_MR1;
					bus.addr   <= 16'h0000; // a7 clear
					wait_q     <= T_MOD_CYC; // covers tmrd too
					st_q       <= DTM_C_WLWAIT;
				end
				DTM_C_WLWAIT: begin
					if (wait_q == 8'h00) begin
						wait_q <= T_RP_CYC;
						st_q   <= DTM_C_PRE;
					end
				end
				DTM_C_PRE: begin
					if (wait_q == 8'h00) begin
						st_q <= DTM_C_ROMRS; // banks idle, trp met
					end
				end
				DTM_C_ROMRS: begin
					bus.cmd    <= DTM_CMD_MRS;
					bus.mr_sel <= MR_SEL_MR3;
					bus.addr   <= 16'h0004; // a2 set, location 00
					wait_q     <= (T_MOD_CYC > T_MRD_CYC) ? T_MOD_CYC : T_MRD_CYC;
					reads_q    <= CAL_READS;
					st_q       <= DTM_C_ROWAIT;
				end
				DTM_C_ROWAIT: begin
					if (wait_q == 8'h00 && bus.dll_locked) begin
						st_q <= DTM_C_RDCMD;
					end
				end
				DTM_C_RDCMD: begin
					bus.cmd  <= DTM_CMD_RD; // only reads here
					bus.addr <= 16'h1000; // a12 set, a2:a0 zero
					reads_q  <= reads_q - 8'h01;
					wait_q   <= 8'({4'h0, READ_LAT_CYC}) + 8'h08 + T_MPRR_CYC;
					st_q     <= DTM_C_RDGAP;
				end
				DTM_C_RDGAP: begin
					if (wait_q == 8'h00) begin
						st_q <= (reads_q == 8'h00) ? DTM_C_OFFMRS : DTM_C_RDCMD;
					end
				end
				DTM_C_OFFMRS: begin
					bus.cmd    <= DTM_CMD_MRS;
					bus.mr_sel <= MR_SEL_MR3;
					bus.addr   <= 16'h0000; // a2 clear
					wait_q     <= T_MOD_CYC;
					st_q       <= DTM_C_OFFWT;
				end
				DTM_C_OFFWT: begin
					if (wait_q == 8'h00) begin
						done <= 1'b1;
						st_q <= DTM_C_IDLE;
					end
				end
				default: begin
					st_q <= DTM_C_IDLE;
				end
			endcase
		end
	end

	// captures dq0 beats of each burst into cal_data_q
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bit_q      <= 3'h0;
			cal_data_q <= 8'h00;
		end else if (bus.dq_valid) begin
			cal_data_q[bit_q] <= bus.dq_o[0];
			bit_q             <= bit_q + 3'h1;
		end
	end

	assign busy = (st_q != DTM_C_IDLE);
endmodule : dtm_ctrl
`default_nettype wire

// ### bench/dtm_assertions.sv
// link checker: timing and data relations on the controller-to-dram link
// assumes plain taps of the link interface, one clock, synchronous reset
`default_nettype none
module dtm_assertions (
	input wire logic             clk_sys,
	input wire logic             rst,
	input wire dtm_pkg::dtm_cmd_t cmd,
	input wire logic [1:0]       mr_sel,
	input wire logic [15:0]      addr,
	input wire logic             odt,
	input wire logic             dqs_oe,
	input wire logic [7:0]       dq_o,
	input wire logic             dq_valid,
	input wire logic             dll_locked
);
	import dtm_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ************************************************************
	// helper: cycles since the last mode register command
	// ************************************************************
	logic [7:0] since_q;
	// saturates, so a long idle stretch never wraps back to a small count
	always_ff @(posedge clk_sys) begin
		if (rst) since_q <= 8'hff;
		else if (cmd == DTM_CMD_MRS) since_q <= 8'h00;
		else if (since_q != 8'hff) since_q <= since_q + 8'h01;
	end
	mrd_gap_a: assert property (cmd == DTM_CMD_MRS |-> since_q >= T_MRD_CYC - 8'h01)
		else $error("mode register commands too close");
	mod_gap_a: assert property (
		cmd != DTM_CMD_NOP && cmd != DTM_CMD_MRS |-> since_q >= T_MOD_CYC - 8'h01)
		else $error("command too soon after mode register command");
	odt_exit_a: assert property (
		cmd == DTM_CMD_MRS && mr_sel == MR_SEL_MR1 |-> !odt && !$past(odt))
		else $error("leveling exit issued with termination on");
	odt_hold_a: assert property ($fell(odt) |=> !odt [*8])
		else $error("odt not kept low");
	strobe_off_a: assert property ($fell(odt) |-> !dqs_oe)
		else $error("strobe still driven at odt drop");
	read_lat_a: assert property (
		cmd == DTM_CMD_RD |-> ##1 !dq_valid [*6] ##1 dq_valid [*8] ##1 !dq_valid)
		else $error("read burst latency or length wrong");
	train_pattern_a: assert property (
		cmd == DTM_CMD_RD && addr[ADDR_BC_BIT] && !addr[ADDR_NIB_BIT] |-> ##7 !dq_o[0]
		##1 dq_o[0] ##1 !dq_o[0] ##1 dq_o[0] ##1 !dq_o[0] ##1 dq_o[0] ##1 !dq_o[0] ##1 dq_o[0])
		else $error("training pattern beats wrong");
	upper_dq_a: assert property (
		dq_valid |-> dq_o[7:1] == 7'h00 || dq_o[7:1] == {7{dq_o[0]}})
		else $error("upper dq neither zero nor copy");
	lock_first_a: assert property (cmd inside {DTM_CMD_RD, DTM_CMD_RDA} |-> dll_locked)
		else $error("read before dll lock");
	no_write_a: assert property (cmd != DTM_CMD_WR)
		else $error("data write during training");
	mprr_gap_a: assert property (
		cmd == DTM_CMD_MRS && mr_sel == MR_SEL_MR3 && !addr[MR3_RO_BIT]
		|-> !dq_valid && !$past(dq_valid))
		else $error("readout disabled too soon after a burst");
	cover property (cmd == DTM_CMD_RD);
	cover property ($fell(odt));
	cover property (cmd == DTM_CMD_MRS && mr_sel == MR_SEL_MR3);
endmodule : dtm_assertions
`default_nettype wire

// ### bench/tb_top.sv
// bench: controller and dram joined, plus a second dram under direct stimulus
// assumes the package and interface are compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dtm_pkg::*;
	logic       clk_sys;
	logic       rst;
	logic       start;
	wire logic  busy;
	wire logic  done;
	wire [7:0]  cal_data;
	wire [4:0]  st1;
	wire [4:0]  st2;
	logic [2:0] flags;
	int         fail_count;
	int         comparisons;
	int         cycles;
	int         w;
	dtm_if link_if (.clk_sys(clk_sys), .rst(rst));
	dtm_if probe_if (.clk_sys(clk_sys), .rst(rst));
	dtm_ctrl dtm_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .bus(link_if.ctrl), .start(start),
		.busy(busy), .done(done), .cal_data_q(cal_data));
	dtm_dram dtm_dram_inst (.bus(link_if.dram), .wl_active(st1[4]), .ro_active(st1[3]),
		.array_read(st1[2]), .array_write(st1[1]), .cmd_illegal(st1[0]));
	dtm_dram dtm_dram_inst2 (.bus(probe_if.dram), .wl_active(st2[4]), .ro_active(st2[3]),
		.array_read(st2[2]), .array_write(st2[1]), .cmd_illegal(st2[0]));
	dtm_assertions dtm_assertions_inst (.clk_sys(clk_sys), .rst(rst), .cmd(link_if.cmd),
		.mr_sel(link_if.mr_sel), .addr(link_if.addr), .odt(link_if.odt),
		.dqs_oe(link_if.dqs_oe), .dq_o(link_if.dq_o), .dq_valid(link_if.dq_valid),
		.dll_locked(link_if.dll_locked));
	// ************************************************************
	// clock, hang guard, shared tasks
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// link device sees no write, no illegal command, no array read while training runs
	always @(negedge clk_sys) begin
		if (busy === 1'b1) begin
			chk({5'h00, st1[2:0]}, 8'h00);
		end
	end
	// one command on the probe link; array and illegal-command flags latched once settled
	task automatic issue(input dtm_cmd_t c, input logic [1:0] s, input logic [15:0] a);
		@(posedge clk_sys);
		probe_if.cmd <= c;
		probe_if.mr_sel <= s;
		probe_if.addr <= a;
		#1 flags = st2[2:0];
		@(posedge clk_sys);
		probe_if.cmd <= DTM_CMD_NOP;
	endtask : issue
	// read, gather n beats from dq0, then expect the burst to have ended
	task automatic burst(input dtm_cmd_t c, input logic [15:0] a, input int n,
		input logic [7:0] exp);
		logic [7:0] v;
		logic       ok;
		int         t;
		v = 8'h00;
		ok = 1'b1;
		t = 0;
		issue(c, 2'h0, a);
		while (probe_if.dq_valid !== 1'b1 && t < 20) begin
			@(negedge clk_sys);
			t++;
		end
		chk({7'h00, probe_if.dq_valid}, 8'h01);
		for (int k = 0; k < n; k++) begin
			v[k] = probe_if.dq_o[0];
			ok = ok & (probe_if.dq_o[7:1] === 7'h00 || probe_if.dq_o[7:1] === {7{v[k]}});
			@(negedge clk_sys);
		end
		chk(v, exp);
		chk({6'h00, ok, probe_if.dq_valid}, 8'h02);
	endtask : burst
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		start = 1'b0;
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		probe_if.cmd = DTM_CMD_NOP;
		probe_if.mr_sel = 2'h0;
		probe_if.addr = 16'h0000;
		probe_if.odt = 1'b1;
		probe_if.dqs_o = 1'b0;
		probe_if.dqs_oe = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		#1 chk({7'h00, busy}, 8'h01);
		w = 0;
		while (done !== 1'b1 && w < 2000) begin
			@(negedge clk_sys);
			w++;
		end
		chk({7'h00, done}, 8'h01);
		chk(cal_data, TRAIN_PATTERN);
		chk({6'h00, st1[4:3]}, 8'h00);
		// probe device: enter leveling, one strobe, then leave
		issue(DTM_CMD_MRS, MR_SEL_MR1, 16'h0080);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		chk({7'h00, st2[4]}, 8'h01);
		probe_if.dqs_oe <= 1'b1;
		probe_if.dqs_o <= 1'b1;
		@(posedge clk_sys);
		probe_if.dqs_o <= 1'b0;
		@(posedge clk_sys);
		#1 chk(probe_if.dq_o, 8'h01);
		probe_if.dqs_oe <= 1'b0;
		probe_if.odt <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk(probe_if.dq_oe, 8'h00);
		issue(DTM_CMD_MRS, MR_SEL_MR1, 16'h0000);
		#1 chk(probe_if.dq_oe, 8'h00);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		chk({7'h00, st2[4]}, 8'h00);
		// normal mode reaches the array
		issue(DTM_CMD_RD, 2'h0, 16'h1000);
		chk({5'h00, flags}, 8'h04);
		issue(DTM_CMD_WR, 2'h0, 16'h0000);
		chk({5'h00, flags}, 8'h02);
		issue(DTM_CMD_MRS, MR_SEL_MR3, 16'h0004);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		chk({7'h00, st2[3]}, 8'h01);
		burst(DTM_CMD_RD, 16'h1000, 8, TRAIN_PATTERN);
		burst(DTM_CMD_RDA, 16'h1000, 8, TRAIN_PATTERN);
		chk({5'h00, flags}, 8'h00);
		burst(DTM_CMD_RD, 16'h6ff8, 4, 8'h0a);
		burst(DTM_CMD_RD, 16'h0004, 4, 8'h0a);
		issue(DTM_CMD_WR, 2'h0, 16'h0000);
		chk({5'h00, flags}, 8'h01);
		issue(DTM_CMD_OTHER, 2'h0, 16'h0000);
		chk({5'h00, flags}, 8'h01);
		// reserved location, then leave readout mode
		issue(DTM_CMD_MRS, MR_SEL_MR3, 16'h0005);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		burst(DTM_CMD_RD, 16'h1000, 8, 8'h00);
		issue(DTM_CMD_MRS, MR_SEL_MR3, 16'h0000);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		chk({7'h00, st2[3]}, 8'h00);
		issue(DTM_CMD_RD, 2'h0, 16'h1000);
		chk({5'h00, flags}, 8'h04);
		// reset inside readout mode, then a read before the dll relocks
		issue(DTM_CMD_MRS, MR_SEL_MR3, 16'h0004);
		repeat (T_MOD_CYC) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1 chk({6'h00, st2[3], probe_if.dll_locked}, 8'h00);
		issue(DTM_CMD_MRS, MR_SEL_MR3, 16'h0004);
		issue(DTM_CMD_RD, 2'h0, 16'h1000);
		w = 0;
		repeat (12) begin
			@(negedge clk_sys);
			if (probe_if.dq_valid !== 1'b0) begin
				w++;
			end
		end
		chk(8'(w), 8'h00);
		burst(DTM_CMD_RD, 16'h1000, 8, TRAIN_PATTERN);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
